/* core/mmx_pkg.sv */
// Package: constants and carrier types of the memory map and external bus
package mmx_pkg;

  // Register offsets in special-register space
  localparam logic [7:0] MMX_AUX_PTR_CTRL_ADDR = 8'hA2;
  localparam logic [7:0] MMX_AUX_CTRL_ADDR     = 8'h8E;

  // Field positions
  localparam int MMX_PTR_SEL_BIT    = 0;
  localparam int MMX_ZERO_BIT       = 2;
  localparam int MMX_FLAG3_BIT      = 3;
  localparam int MMX_EXT_XDATA_BIT  = 1;
  localparam int MMX_XSIZE_BIT      = 2;
  localparam int MMX_STRETCH_BIT    = 0;

  // Reset values
  localparam logic [7:0] MMX_AUX_PTR_CTRL_RST = 8'h00;
  localparam logic [7:0] MMX_AUX_CTRL_RST     = 8'h00;
  localparam logic [15:0] MMX_RESET_PC        = 16'h0000;

  // Internal extended RAM windows
  localparam logic [15:0] MMX_EXTENDED_DATA_RAM_END_SMALL = 16'h00FF;
  localparam logic [15:0] MMX_EXTENDED_DATA_RAM_END_LARGE = 16'h01FF;
  localparam int          MMX_EXTENDED_DATA_RAM_DEPTH     = 512;

  // Lower/upper internal RAM boundary
  localparam logic [7:0] MMX_UPPER_BASE = 8'h80;

  // Strobe and address-phase widths in clock periods
  localparam int MMX_STROBE_NORMAL  = 6;
  localparam int MMX_STROBE_STRETCH = 30;
  localparam int MMX_ADDR_CYCLES    = 2;

  // Access kinds from the core
  typedef enum logic [3:0] {
    MMX_K_FETCH  = 4'b0001,
    MMX_K_XRI    = 4'b0010,
    MMX_K_XPTR   = 4'b0100,
    MMX_K_NONE   = 4'b1000
  } mmx_kind_t;

  // External bus outputs
  typedef struct packed {
    logic [7:0] p0Out;
    logic       p0Oe;
    logic [7:0] p2Out;
    logic       p2Oe;
    logic       addrLatch;
    logic       progReadN;
    logic       readN;
    logic       writeN;
  } mmx_bus_t;

  // Core request
  typedef struct packed {
    mmx_kind_t  kind;
    logic       write;
    logic [15:0] pc;
    logic [7:0] riAddr;
    logic [7:0] wdata;
  } mmx_req_t;

endpackage

/* core/mmx_extended_data_ram.sv */
// Internal extended-data RAM with registered read data
`timescale 1ns/1ps
module mmx_extended_data_ram #(
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  input  wire logic          clk_sys,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // mmx_extended_data_ram

/* core/mmx_ext_bus.sv */
// Memory-map decode, dual data pointers and external bus sequencer
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module mmx_ext_bus
  import mmx_pkg::*;
#(
  parameter int EXTENDED_DATA_RAM_DEPTH = MMX_EXTENDED_DATA_RAM_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        codeSourceStrap,
  input  wire mmx_req_t    req,
  input  wire logic        reqValid,
  output logic             reqReady,
  output logic             respValid,
  output logic [7:0]       respData,
  input  wire logic [7:0]  p0In,
  output mmx_bus_t         bus,
  input  wire logic        sfrWe,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic [7:0]  sfrWdata,
  output logic [7:0]       sfrRdata,
  input  wire logic        ptrWe,
  input  wire logic [15:0] ptrWdata,
  output logic [15:0]      dataPointer,
  input  wire logic        ramDirect,
  input  wire logic        ramStack,
  input  wire logic [7:0]  ramAddr,
  output logic             ramSfrSel,
  output logic             ramUpperSel,
  output logic [7:0]       ramIndex,
  output logic             internalFetch,
  output logic [15:0]      resetPc
);
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_ADDR  = 5'b00010,
    S_STRB  = 5'b00100,
    S_INT   = 5'b01000,
    S_DONE  = 5'b10000
  } mmx_state_t;

  localparam logic [4:0] STRB_N = 5'(MMX_STROBE_NORMAL - 1);
  localparam logic [4:0] STRB_S = 5'(MMX_STROBE_STRETCH - 1);

  mmx_state_t  state_reg;
  logic [4:0]  cnt_reg;
  logic [7:0]  auxPtr_reg;
  logic [7:0]  auxCtrl_reg;
  logic [15:0] ptr0_reg;
  logic [15:0] ptr1_reg;
  mmx_req_t    cur_reg;
  logic [15:0] xaddr_reg;
  logic [7:0]  rdata_reg;
  logic        ext_reg;
  logic        xWe;
  logic [7:0]  xRdata;
  logic [15:0] xEnd;
  logic        goExt;
  logic        ptrSel;

  //////////////////////////////////////////////////////////////////////////
  // Special registers
  assign ptrSel = auxPtr_reg[MMX_PTR_SEL_BIT];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      auxPtr_reg  <= MMX_AUX_PTR_CTRL_RST;
      auxCtrl_reg <= MMX_AUX_CTRL_RST;
    end else if (sfrWe && sfrAddr == MMX_AUX_PTR_CTRL_ADDR) begin
      // Bit 2 stuck at zero so an increment never carries into bit 3
      auxPtr_reg <= sfrWdata & ~(8'h01 << MMX_ZERO_BIT);
    end else if (sfrWe && sfrAddr == MMX_AUX_CTRL_ADDR) begin
      auxCtrl_reg <= sfrWdata & 8'h07;
    end
  end

  always_comb begin
    if (sfrAddr == MMX_AUX_PTR_CTRL_ADDR) begin
      sfrRdata = auxPtr_reg & ~(8'h01 << MMX_ZERO_BIT);
    end else if (sfrAddr == MMX_AUX_CTRL_ADDR) begin
      sfrRdata = auxCtrl_reg;
    end else begin
      sfrRdata = 8'h00;
    end
  end

  // Two data pointers, only the selected one is loaded
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ptr0_reg <= 16'h0000;
      ptr1_reg <= 16'h0000;
    end else if (ptrWe && !ptrSel) begin
      ptr0_reg <= ptrWdata;
    end else if (ptrWe && ptrSel) begin
      ptr1_reg <= ptrWdata;
    end
  end
  assign dataPointer = ptrSel ? ptr1_reg : ptr0_reg;

  //////////////////////////////////////////////////////////////////////////
  // Internal RAM decode
  always_comb begin
    ramSfrSel   = 1'b0;
    ramUpperSel = 1'b0;
    ramIndex    = ramAddr;
    if (ramAddr >= MMX_UPPER_BASE) begin
      // Stack behaves as indirect, never reaches SFRs or ext RAM
      ramSfrSel   = ramDirect && !ramStack;
      ramUpperSel = !ramDirect || ramStack;
    end
  end

  assign internalFetch = codeSourceStrap;
  assign resetPc       = MMX_RESET_PC;

  //////////////////////////////////////////////////////////////////////////
  // Extended-data decode
  assign xEnd = auxCtrl_reg[MMX_XSIZE_BIT] ? MMX_EXTENDED_DATA_RAM_END_LARGE
                                           : MMX_EXTENDED_DATA_RAM_END_SMALL;
  always_comb begin
    goExt = 1'b0;
    if (req.kind == MMX_K_FETCH) begin
      goExt = !codeSourceStrap;
    end else if (auxCtrl_reg[MMX_EXT_XDATA_BIT]) begin
      goExt = 1'b1;
    end else if (req.kind == MMX_K_XPTR) begin
      goExt = dataPointer > xEnd;
    end
  end

  assign xWe = state_reg == S_IDLE && reqValid && !goExt && req.write &&
               req.kind != MMX_K_FETCH && req.kind != MMX_K_NONE;

  mmx_extended_data_ram #(
    .DEPTH (EXTENDED_DATA_RAM_DEPTH),
    .AW    (9)
  ) u_extended_data_ram (
    .clk_sys (clk_sys),
    .we      (xWe),
    .addr    (req.kind == MMX_K_XPTR ? dataPointer[8:0]
                                     : {1'b0, req.riAddr}),
    .wdata   (req.wdata),
    .rdata   (xRdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Bus sequencer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 5'h00;
      cur_reg   <= '0;
      xaddr_reg <= 16'h0000;
      ext_reg   <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (reqValid && req.kind != MMX_K_NONE) begin
            cur_reg <= req;
            ext_reg <= goExt;
            cnt_reg <= 5'(MMX_ADDR_CYCLES - 1);
            if (req.kind == MMX_K_FETCH) begin
              xaddr_reg <= req.pc;
            end else if (req.kind == MMX_K_XPTR) begin
              xaddr_reg <= dataPointer;
            end else begin
              xaddr_reg <= {8'h00, req.riAddr};
            end
            state_reg <= goExt ? S_ADDR : S_INT;
          end
        end
        S_ADDR: begin
          if (cnt_reg == 5'h00) begin
            state_reg <= S_STRB;
            if (cur_reg.kind != MMX_K_FETCH &&
                auxCtrl_reg[MMX_STRETCH_BIT]) begin
              cnt_reg <= STRB_S;
            end else begin
              cnt_reg <= STRB_N;
            end
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        S_STRB: begin
          if (cnt_reg == 5'h00) begin
            state_reg <= S_DONE;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        S_INT: state_reg <= S_DONE;
        S_DONE: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Capture read data at end of strobe, or from internal RAM
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (state_reg == S_STRB && cnt_reg == 5'h00) begin
      rdata_reg <= p0In;
    end else if (state_reg == S_INT) begin
      rdata_reg <= xRdata;
    end
  end

  assign reqReady  = state_reg == S_IDLE;
  assign respValid = state_reg == S_DONE;
  assign respData  = rdata_reg;

  // Pin drive; internal cycles leave ports and strobes idle
  always_comb begin
    bus           = '0;
    bus.progReadN = 1'b1;
    bus.readN     = 1'b1;
    bus.writeN    = 1'b1;
    if (state_reg == S_ADDR) begin
      bus.p0Out     = xaddr_reg[7:0];
      bus.p0Oe      = 1'b1;
      bus.addrLatch = cnt_reg != 5'h00;
      bus.p2Out     = xaddr_reg[15:8];
      bus.p2Oe      = cur_reg.kind != MMX_K_XRI;
    end else if (state_reg == S_STRB) begin
      bus.p2Out = xaddr_reg[15:8];
      bus.p2Oe  = cur_reg.kind != MMX_K_XRI;
      if (cur_reg.kind == MMX_K_FETCH) begin
        bus.progReadN = 1'b0;
      end else if (cur_reg.write) begin
        bus.writeN = 1'b0;
        bus.p0Out  = cur_reg.wdata;
        bus.p0Oe   = 1'b1;
      end else begin
        bus.readN = 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_strobe_len;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(bus.readN) && !auxCtrl_reg[MMX_STRETCH_BIT] |->
      !bus.readN [*6] ##1 bus.readN;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("read strobe not 6 cycles");

  property p_strobe_long;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(bus.writeN) && auxCtrl_reg[MMX_STRETCH_BIT] |->
      ##29 !bus.writeN ##1 bus.writeN;
  endproperty
  a_strobe_long: assert property (p_strobe_long)
    else $error("stretched write strobe not 30 cycles");

  // Low-cycle count of the data strobes; a repetition of 30 is too costly
  logic [5:0] lowCnt_reg;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lowCnt_reg <= 6'h00;
    end else if (!bus.readN || !bus.writeN) begin
      lowCnt_reg <= lowCnt_reg + 6'h01;
    end else begin
      lowCnt_reg <= 6'h00;
    end
  end

  property p_strobe_count;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(bus.readN && bus.writeN) |->
      lowCnt_reg == (auxCtrl_reg[MMX_STRETCH_BIT] ? 6'(MMX_STROBE_STRETCH)
                                                  : 6'(MMX_STROBE_NORMAL));
  endproperty
  a_strobe_count: assert property (p_strobe_count)
    else $error("data strobe length wrong");

  property p_int_fetch;
    @(posedge clk_sys) disable iff (!nrst)
    codeSourceStrap |-> bus.progReadN;
  endproperty
  a_int_fetch: assert property (p_int_fetch)
    else $error("program read during internal fetch");

  property p_int_extended_data_ram;
    @(posedge clk_sys) disable iff (!nrst)
    state_reg == S_INT |-> bus.readN && bus.writeN && !bus.p0Oe && !bus.p2Oe;
  endproperty
  a_int_extended_data_ram: assert property (p_int_extended_data_ram)
    else $error("bus active on internal extended_data_ram");

  property p_idle_high;
    @(posedge clk_sys) disable iff (!nrst)
    state_reg == S_IDLE |-> bus.readN && bus.writeN && bus.progReadN;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("strobe low while idle");

  property p_bit2_zero;
    @(posedge clk_sys) disable iff (!nrst)
    sfrAddr == MMX_AUX_PTR_CTRL_ADDR |-> !sfrRdata[MMX_ZERO_BIT];
  endproperty
  a_bit2_zero: assert property (p_bit2_zero)
    else $error("bit 2 reads one");

  property p_ptr_sel;
    @(posedge clk_sys) disable iff (!nrst)
    ptrWe && !ptrSel ##1 !ptrSel |-> dataPointer == $past(ptrWdata);
  endproperty
  a_ptr_sel: assert property (p_ptr_sel)
    else $error("pointer 0 not loaded");

  property p_upper;
    @(posedge clk_sys) disable iff (!nrst)
    ramAddr[7] && !ramDirect |-> ramUpperSel && !ramSfrSel;
  endproperty
  a_upper: assert property (p_upper)
    else $error("indirect access reached SFR");

  property p_fetch_addr;
    @(posedge clk_sys) disable iff (!nrst)
    state_reg == S_IDLE && reqValid && req.kind == MMX_K_FETCH &&
      !codeSourceStrap |-> ##1 bus.addrLatch && bus.p0Out == $past(req.pc[7:0]);
  endproperty
  a_fetch_addr: assert property (p_fetch_addr)
    else $error("fetch address not driven");

  c_ext_fetch: cover property (@(posedge clk_sys) !bus.progReadN);
  c_ext_read:  cover property (@(posedge clk_sys) !bus.readN);
  c_ext_write: cover property (@(posedge clk_sys)
    !bus.writeN && auxCtrl_reg[MMX_STRETCH_BIT]);
  c_int_extended_data_ram:  cover property (@(posedge clk_sys) state_reg == S_INT);
endmodule // mmx_ext_bus

/* verif/mmx_ext_mem.sv */
// External program and data memory model on the multiplexed bus
`timescale 1ns/1ps
module mmx_ext_mem
  import mmx_pkg::*;
#(
  parameter int READ_DELAY = 2
) (
  input  wire logic     clk_sys,
  input  wire mmx_bus_t bus,
  output logic [7:0]    p0In
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addrReg;
  logic [7:0]  lastReg = 8'h00;
  int          waitReg = 0;
  logic        rdActive;

  assign rdActive = !bus.readN || !bus.progReadN;

  //////////////////////////////////////////////////////////////////////////
  // No page byte on port 2 means page 00
  always_ff @(posedge clk_sys) begin
    if (bus.addrLatch) begin
      addrReg <= {bus.p2Oe ? bus.p2Out : 8'h00, bus.p0Out};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!bus.writeN && bus.p0Oe) begin
      mem[addrReg] <= bus.p0Out;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Slow part: data only after the access delay
  always_ff @(posedge clk_sys) begin
    waitReg <= rdActive ? waitReg + 1 : 0;
    lastReg <= p0In;
  end

  // Floating bus never shows a held copy
  assign p0In = (rdActive && waitReg >= READ_DELAY) ? mem[addrReg] : ~lastReg;
endmodule // mmx_ext_mem

/* verif/mcu_memory_map_ext_bus_tb_top.sv */
// Testbench of the memory map and external bus block
`timescale 1ns/1ps
module mcu_memory_map_ext_bus_tb_top;
  import mmx_pkg::*;
  mmx_req_t    req;
  mmx_bus_t    bus;
  logic        clk_sys, nrst, codeSourceStrap, reqValid, reqReady;
  logic        respValid, sfrWe, ptrWe, ramDirect, ramStack, ramSfrSel;
  logic        ramUpperSel, internalFetch, p2Seen;
  logic [7:0]  respData, p0In, memOut, sfrAddr, sfrWdata, sfrRdata;
  logic [7:0]  ramAddr, ramIndex, q;
  logic [15:0] ptrWdata, dataPointer, resetPc;
  int          numErrors, comparisons, n;

  // Port 0 level from both parties
  assign p0In = bus.p0Oe ? bus.p0Out : memOut;

  mmx_ext_bus dut (.clk_sys(clk_sys), .nrst(nrst),
    .codeSourceStrap(codeSourceStrap), .req(req), .reqValid(reqValid),
    .reqReady(reqReady), .respValid(respValid), .respData(respData),
    .p0In(p0In), .bus(bus), .sfrWe(sfrWe), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .ptrWe(ptrWe),
    .ptrWdata(ptrWdata), .dataPointer(dataPointer), .ramDirect(ramDirect),
    .ramStack(ramStack), .ramAddr(ramAddr), .ramSfrSel(ramSfrSel),
    .ramUpperSel(ramUpperSel), .ramIndex(ramIndex),
    .internalFetch(internalFetch), .resetPc(resetPc));

  mmx_ext_mem partner (.clk_sys(clk_sys), .bus(bus), .p0In(memOut));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (numErrors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] got);
    comparisons++;
    if (got !== e) begin
      numErrors++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask

  // Counts strobe-low cycles into n, read byte into q
  task automatic xfer(input mmx_kind_t k, input logic w,
                      input logic [15:0] a, input logic [7:0] d);
    int i;
    @(negedge clk_sys);
    check("reqReady", 16'h0001, {15'h0000, reqReady});
    req = '{kind: k, write: w, pc: a, riAddr: a[7:0], wdata: d};
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b0;
    req.kind = MMX_K_NONE;
    n = 0;
    check("reqBusy", 16'h0000, {15'h0000, reqReady});
    p2Seen = 1'b0;
    for (i = 0; i < 60 && respValid !== 1'b1; i++) begin
      if (bus.readN === 1'b0 || bus.writeN === 1'b0
          || bus.progReadN === 1'b0) n++;
      if (bus.p2Oe === 1'b1) p2Seen = 1'b1;
      @(negedge clk_sys);
    end
    q = respData;
    if (i == 60) begin
      numErrors++;
      $display("Error respValid expected 1 seen 0");
      finish_test();
    end
  endtask

  task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfrWe = 1'b1;
    sfrAddr = a;
    sfrWdata = d;
    @(negedge clk_sys);
    sfrWe = 1'b0;
  endtask

  task automatic sfrCheck(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfrAddr = a;
    #1 check("sfrRdata", {8'h00, e}, {8'h00, sfrRdata});
  endtask

  task automatic ptrLoad(input logic [15:0] v);
    @(negedge clk_sys);
    ptrWe = 1'b1;
    ptrWdata = v;
    @(negedge clk_sys);
    ptrWe = 1'b0;
  endtask

  task automatic ramCheck(input logic dir, input logic stk,
                          input logic [7:0] a, input logic s, input logic u);
    @(negedge clk_sys);
    ramDirect = dir;
    ramStack = stk;
    ramAddr = a;
    #1 check("ramSfrSel", {15'h0000, s}, {15'h0000, ramSfrSel});
    check("ramUpperSel", {15'h0000, u}, {15'h0000, ramUpperSel});
    check("ramIndex", {8'h00, a}, {8'h00, ramIndex});
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    codeSourceStrap = 1'b1;
    req = '{kind: MMX_K_NONE, default: '0};
    {reqValid, sfrWe, ptrWe, ramDirect, ramStack} = 5'h00;
    {sfrAddr, sfrWdata, ramAddr, ptrWdata} = 40'h00_0000_0000;
    numErrors = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check("strobes", 16'h0007,
          {13'h0000, bus.progReadN, bus.readN, bus.writeN});
    nrst = 1'b1;
    sfrCheck(MMX_AUX_PTR_CTRL_ADDR, 8'h00);
    sfrCheck(MMX_AUX_CTRL_ADDR, 8'h00);
    check("resetPc", 16'h0000, resetPc);
    check("internalFetch", 16'h0001, {15'h0000, internalFetch});
    xfer(MMX_K_FETCH, 1'b0, 16'h1234, 8'h00);
    check("fetchStrobe", 16'h0000, n[15:0]);
    check("p2Oe", 16'h0000, {15'h0000, p2Seen});
    ramCheck(1'b1, 1'b0, 8'h20, 1'b0, 1'b0);
    ramCheck(1'b0, 1'b0, 8'h7F, 1'b0, 1'b0);
    ramCheck(1'b1, 1'b0, 8'h90, 1'b1, 1'b0);
    ramCheck(1'b0, 1'b0, 8'h80, 1'b0, 1'b1);
    ramCheck(1'b1, 1'b1, 8'hA0, 1'b0, 1'b1);
    ptrLoad(16'h0010);
    xfer(MMX_K_XPTR, 1'b1, 16'h0010, 8'h77);
    check("intWrStrobe", 16'h0000, n[15:0]);
    xfer(MMX_K_XPTR, 1'b0, 16'h0010, 8'h00);
    check("intRead", 16'h0077, {8'h00, q});
    check("intRdStrobe", 16'h0000, n[15:0]);
    ptrLoad(16'h0150);
    xfer(MMX_K_XPTR, 1'b1, 16'h0150, 8'h5E);
    check("rollStrobe", 16'h0006, n[15:0]);
    sfrWrite(MMX_AUX_CTRL_ADDR, 8'h04);
    xfer(MMX_K_XPTR, 1'b1, 16'h0150, 8'h11);
    check("bigWrStrobe", 16'h0000, n[15:0]);
    xfer(MMX_K_XPTR, 1'b0, 16'h0150, 8'h00);
    check("bigRead", 16'h0011, {8'h00, q});
    sfrWrite(MMX_AUX_CTRL_ADDR, 8'h02);
    xfer(MMX_K_XPTR, 1'b0, 16'h0150, 8'h00);
    check("extRead", 16'h005E, {8'h00, q});
    check("extRdStrobe", 16'h0006, n[15:0]);
    ptrLoad(16'h3344);
    xfer(MMX_K_XPTR, 1'b1, 16'h3344, 8'hC3);
    check("extWrStrobe", 16'h0006, n[15:0]);
    ptrLoad(16'h0044);
    xfer(MMX_K_XPTR, 1'b1, 16'h0044, 8'h3C);
    xfer(MMX_K_XRI, 1'b0, 16'h0044, 8'h00);
    check("riRead", 16'h003C, {8'h00, q});
    check("riP2Oe", 16'h0000, {15'h0000, p2Seen});
    ptrLoad(16'h3344);
    sfrWrite(MMX_AUX_CTRL_ADDR, 8'h03);
    xfer(MMX_K_XPTR, 1'b0, 16'h3344, 8'h00);
    check("ptrRead", 16'h00C3, {8'h00, q});
    check("stretch", 16'h001E, n[15:0]);
    xfer(MMX_K_XPTR, 1'b1, 16'h3344, 8'hA5);
    check("stretchWr", 16'h001E, n[15:0]);
    sfrWrite(MMX_AUX_CTRL_ADDR, 8'h02);
    codeSourceStrap = 1'b0;
    #1 check("internalFetch", 16'h0000, {15'h0000, internalFetch});
    xfer(MMX_K_FETCH, 1'b0, 16'h3344, 8'h00);
    check("extFetch", 16'h00A5, {8'h00, q});
    check("fetchStrobe", 16'h0006, n[15:0]);
    sfrWrite(MMX_AUX_PTR_CTRL_ADDR, 8'h00);
    ptrLoad(16'h1111);
    sfrWrite(MMX_AUX_PTR_CTRL_ADDR, 8'h01);
    ptrLoad(16'h2222);
    check("dataPointer", 16'h2222, dataPointer);
    sfrWrite(MMX_AUX_PTR_CTRL_ADDR, 8'h0C);
    sfrCheck(MMX_AUX_PTR_CTRL_ADDR, 8'h08);
    check("dataPointer", 16'h1111, dataPointer);
    sfrWrite(MMX_AUX_PTR_CTRL_ADDR, 8'h09);
    sfrCheck(MMX_AUX_PTR_CTRL_ADDR, 8'h09);
    check("dataPointer", 16'h2222, dataPointer);
    sfrWrite(MMX_AUX_PTR_CTRL_ADDR, 8'h0A);
    sfrCheck(MMX_AUX_PTR_CTRL_ADDR, 8'h0A);
    check("dataPointer", 16'h1111, dataPointer);
    finish_test();
  end
endmodule // mcu_memory_map_ext_bus_tb_top
